// ---- rtl/fwlsp_top.sv ----
// Write-enable latch and per-sector protection flags of a serial flash.
// Assumes the lock bit and the engines outside run on the same clock
// and that the link pins are asynchronous to it.
`timescale 1ns/10ps
`default_nettype none
`include "fwlsp_regs.svh"

// Behaviour
// [RULE1] Guarded commands run only if the write-enable latch was already set.
// [RULE2] Opcode 06h, completed, sets the latch at frame end; extra bytes ignored.
// [RULE3] A partial enable or disable opcode leaves the latch unchanged.
// [RULE4] Opcode 04h, completed, clears the latch at frame end.
// [RULE5] A completed write disable also ends sequential programming mode.
// [RULE6] Reset sets every sector flag to protected.
// [RULE7] Flag zero allows program and erase; flag one blocks both.
// [RULE8] Opcode 36h plus three address bytes protects the addressed sector.
// [RULE9] A completed protect or unprotect also clears the latch.
// [RULE10] Opcode 39h plus three address bytes unprotects the addressed sector.
// [RULE11] Address cut short: flags unchanged, latch cleared.
// [RULE12] While flags are locked, protect and unprotect only clear the latch.
// [RULE13] Program or block erase into a protected sector is dropped.
// [RULE14] Chip erase with any sector protected is dropped and clears the latch.
// [RULE15] Bytes arrive MSB first on rising serial clock, one frame per command.
module fwlsp_top #(
    parameter int NSEC = 16                      // Number of physical sectors
) (
    input  wire logic            clock,          // System clock, 10 MHz
    input  wire logic            rstn,           // Async reset, active low
    input  wire logic            cs_n,           // Chip select pin, active low
    input  wire logic            sck,            // Serial clock pin
    input  wire logic            si,             // Serial data in pin
    input  wire logic            protection_flags_lock, // Flags locked
    output logic                 write_enable_latch,    // Latch state
    output logic [NSEC-1:0]      sector_flags,   // 1 = sector protected
    output logic                 seq_mode_exit,  // Pulse: leave sequential mode
    output logic                 exec_start,     // Pulse: start program/erase
    output logic [7:0]           exec_opcode,    // Opcode of started operation
    output logic [23:0]          exec_addr,      // Address of started operation
    output logic                 status_write    // Pulse: status write allowed
);

    localparam int SW = (NSEC > 1) ? $clog2(NSEC) : 1;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    fwlsp_pkg::fwlsp_state_t state_q;
    logic [2:0]        cnt_q;
    logic [7:0]        opcode_q;
    logic [23:0]       addr_q;
    logic              rx_valid;
    logic [7:0]        rx_byte;
    logic              rx_end;
    logic              wen_q, wen_d;
    logic [NSEC-1:0]   flags_q, flags_d;
    logic              seq_d, exec_d, wsr_d;
    logic [SW-1:0]     sec_w;
    logic              op_done, addr_done, data_done;

    // Sector holding a 24-bit address
    function automatic logic [SW-1:0] sector_of(input logic [23:0] a);
        sector_of = a[`FWLSP_SECTOR_LSB +: SW];
    endfunction

    // Commands that carry three address bytes
    function automatic logic has_addr(input logic [7:0] op);
        has_addr = (op == `FWLSP_OP_PROT) || (op == `FWLSP_OP_UNPROT) ||
                   (op == `FWLSP_OP_PROGRAM) || (op == `FWLSP_OP_ERASE_4K) ||
                   (op == `FWLSP_OP_ERASE_32K) || (op == `FWLSP_OP_ERASE_64K);
    endfunction

    // ****************************************************************
    // Receiver
    // ****************************************************************
    fwlsp_rx u_rx (
        .clock      (clock),
        .rstn       (rstn),
        .cs_n       (cs_n),
        .sck        (sck),
        .si         (si),
        .byte_valid (rx_valid),
        .byte_data  (rx_byte),
        .frame_end  (rx_end)
    );

    // ****************************************************************
    // Frame parser
    // ****************************************************************
    // Byte count saturates once a data byte is seen; later bytes ignored
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 3'h0;
        end else if (rx_end) begin
            cnt_q <= 3'h0;
        end else if (rx_valid && cnt_q != `FWLSP_CNT_DATA) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // Parser state returns to idle at every frame end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= fwlsp_pkg::FWLSP_S_IDLE;
        end else if (rx_end) begin
            state_q <= fwlsp_pkg::FWLSP_S_IDLE;  // RULE13
        end else if (rx_valid) begin
            case (state_q)
                fwlsp_pkg::FWLSP_S_IDLE: begin
                    if (has_addr(rx_byte)) begin
                        state_q <= fwlsp_pkg::FWLSP_S_ADDR;
                    end else begin
                        state_q <= fwlsp_pkg::FWLSP_S_TAIL;
                    end
                end
                fwlsp_pkg::FWLSP_S_ADDR: begin
                    if (cnt_q == `FWLSP_CNT_ADDR - 3'h1) begin
                        state_q <= fwlsp_pkg::FWLSP_S_DATA;
                    end
                end
                fwlsp_pkg::FWLSP_S_DATA: begin
                    state_q <= fwlsp_pkg::FWLSP_S_DATA;
                end
                fwlsp_pkg::FWLSP_S_TAIL: begin
                    state_q <= fwlsp_pkg::FWLSP_S_TAIL;  // RULE2
                end
                default: begin
                    state_q <= fwlsp_pkg::FWLSP_S_IDLE;
                end
            endcase
        end
    end

    // Opcode and address capture, address MSB byte first
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            opcode_q <= 8'h00;
            addr_q   <= 24'h000000;
        end else if (rx_valid) begin
            if (state_q == fwlsp_pkg::FWLSP_S_IDLE) begin
                opcode_q <= rx_byte;
            end else if (state_q == fwlsp_pkg::FWLSP_S_ADDR) begin
                addr_q <= {addr_q[15:0], rx_byte};  // RULE15
            end
        end
    end

    assign op_done   = (cnt_q >= `FWLSP_CNT_OPCODE);
    assign addr_done = (cnt_q >= `FWLSP_CNT_ADDR);
    assign data_done = (cnt_q >= `FWLSP_CNT_DATA);
    assign sec_w     = sector_of(addr_q);

    // ****************************************************************
    // Command decision at frame end
    // ****************************************************************
    // Everything acts only at chip select release, so a cut frame never
    // leaves half an update behind
    always_comb begin
        wen_d   = wen_q;
        flags_d = flags_q;
        seq_d   = 1'b0;
        exec_d  = 1'b0;
        wsr_d   = 1'b0;
        if (rx_end && op_done) begin
            case (opcode_q)
                `FWLSP_OP_WREN: begin
                    wen_d = 1'b1;  // RULE2
                end
                `FWLSP_OP_WRDI: begin
                    wen_d = 1'b0;  // RULE4
                    seq_d = 1'b1;  // RULE5
                end
                `FWLSP_OP_PROT: begin
                    if (addr_done && wen_q && !protection_flags_lock) begin
                        flags_d[sec_w] = `FWLSP_FLAG_PROT;  // RULE8
                    end
                    wen_d = 1'b0;  // RULE9 RULE11 RULE12
                end
                `FWLSP_OP_UNPROT: begin
                    if (addr_done && wen_q && !protection_flags_lock) begin
                        flags_d[sec_w] = `FWLSP_FLAG_OPEN;  // RULE10
                    end
                    wen_d = 1'b0;  // RULE9 RULE11 RULE12
                end
                `FWLSP_OP_PROGRAM: begin
                    exec_d = wen_q && data_done && !flags_q[sec_w];  // RULE1 RULE7
                    wen_d  = 1'b0;
                end
                `FWLSP_OP_ERASE_4K, `FWLSP_OP_ERASE_32K,
                `FWLSP_OP_ERASE_64K: begin
                    exec_d = wen_q && addr_done && !flags_q[sec_w];  // RULE1 RULE13
                    wen_d  = 1'b0;
                end
                `FWLSP_OP_CHIP_A, `FWLSP_OP_CHIP_B: begin
                    exec_d = wen_q && (flags_q == '0);  // RULE1 RULE14
                    wen_d  = 1'b0;  // RULE14
                end
                `FWLSP_OP_WSR: begin
                    // Opcode plus one status byte is enough here
                    wsr_d = wen_q && (cnt_q >= `FWLSP_CNT_STATUS);  // RULE1
                end
                default: begin
                    wen_d = wen_q;
                end
            endcase
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    // Latch and flags; a short opcode never reaches here
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wen_q   <= `FWLSP_WEN_RST;
            flags_q <= {NSEC{`FWLSP_FLAG_PROT}};  // RULE6
        end else begin
            wen_q   <= wen_d;  // RULE3
            flags_q <= flags_d;
        end
    end

    // Output pulses and the operation handed to the engines
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            seq_mode_exit <= 1'b0;
            exec_start    <= 1'b0;
            status_write  <= 1'b0;
            exec_opcode   <= 8'h00;
            exec_addr     <= 24'h000000;
        end else begin
            seq_mode_exit <= seq_d;
            exec_start    <= exec_d;
            status_write  <= wsr_d;
            if (exec_d) begin
                exec_opcode <= opcode_q;
                exec_addr   <= addr_q;
            end
        end
    end

    // Mirrors kept as flops so the ports come straight from registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            write_enable_latch <= `FWLSP_WEN_RST;
            sector_flags       <= {NSEC{`FWLSP_FLAG_PROT}};
        end else begin
            write_enable_latch <= wen_d;
            sector_flags       <= flags_d;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_wren_sets_wen: assert property ( // RULE2
        rx_end && op_done && opcode_q == `FWLSP_OP_WREN |=> wen_q ##1 write_enable_latch)
        else $error("write enable did not set latch");

    a_short_frame_keeps: assert property ( // RULE3
        rx_end && !op_done |=> $stable(wen_q) && $stable(flags_q))
        else $error("short opcode changed state");

    a_wrdi_clears_wen: assert property ( // RULE4
        rx_end && op_done && opcode_q == `FWLSP_OP_WRDI |=> !wen_q)
        else $error("write disable did not clear latch");

    a_wrdi_ends_seq: assert property ( // RULE5
        seq_mode_exit |-> $past(opcode_q) == `FWLSP_OP_WRDI && !wen_q)
        else $error("sequential exit without write disable");

    a_prot_sets_flag: assert property ( // RULE8
        rx_end && addr_done && wen_q && !protection_flags_lock &&
        opcode_q == `FWLSP_OP_PROT |=> flags_q[$past(sec_w)])
        else $error("protect did not set flag");

    a_unprot_clr_flag: assert property ( // RULE10
        rx_end && addr_done && wen_q && !protection_flags_lock &&
        opcode_q == `FWLSP_OP_UNPROT |=> !flags_q[$past(sec_w)])
        else $error("unprotect did not clear flag");

    a_prot_clears_wen: assert property ( // RULE9
        rx_end && op_done && (opcode_q == `FWLSP_OP_PROT ||
        opcode_q == `FWLSP_OP_UNPROT) |=> !wen_q ##1 !write_enable_latch)
        else $error("protect command left latch set");

    a_lock_holds_flags: assert property ( // RULE12
        rx_end && (protection_flags_lock || !addr_done) |=> $stable(flags_q))
        else $error("flags changed while locked or cut short");

    a_exec_needs_wen: assert property ( // RULE1
        exec_start |-> $past(wen_q) && !wen_q)
        else $error("operation started without latch");

    a_exec_open_sector: assert property ( // RULE7
        exec_start && exec_opcode != `FWLSP_OP_CHIP_A &&
        exec_opcode != `FWLSP_OP_CHIP_B |-> !flags_q[sector_of(exec_addr)])
        else $error("operation started in protected sector");

    a_chip_all_open: assert property ( // RULE14
        exec_start && (exec_opcode == `FWLSP_OP_CHIP_A ||
        exec_opcode == `FWLSP_OP_CHIP_B) |-> flags_q == '0)
        else $error("chip erase with protected sector");

    a_end_to_idle: assert property ( // RULE13
        rx_end |=> state_q == fwlsp_pkg::FWLSP_S_IDLE && cnt_q == 3'h0)
        else $error("parser not idle after frame end");

    c_wren_done: cover property (
        rx_end && opcode_q == `FWLSP_OP_WREN && op_done);
    c_unprot_done: cover property (
        rx_end && opcode_q == `FWLSP_OP_UNPROT && addr_done && wen_q);
    c_exec_started: cover property (exec_start);
    c_lock_refused: cover property (
        rx_end && protection_flags_lock && opcode_q == `FWLSP_OP_UNPROT);

endmodule
`default_nettype wire

// ---- pkg/fwlsp_regs.svh ----
// Constants of the flash command and sector protection block.
// Assumes inclusion by bare name; definitions only.
`ifndef FWLSP_REGS_SVH
`define FWLSP_REGS_SVH

// ****************************************************************
// Opcodes
// ****************************************************************
`define FWLSP_OP_WREN      8'h06
`define FWLSP_OP_WRDI      8'h04
`define FWLSP_OP_PROT      8'h36
`define FWLSP_OP_UNPROT    8'h39
`define FWLSP_OP_PROGRAM   8'h02
`define FWLSP_OP_ERASE_4K  8'h20
`define FWLSP_OP_ERASE_32K 8'h52
`define FWLSP_OP_ERASE_64K 8'hD8
`define FWLSP_OP_CHIP_A    8'h60
`define FWLSP_OP_CHIP_B    8'hC7
`define FWLSP_OP_WSR       8'h01

// ****************************************************************
// Frame byte counts (opcode, address, first data byte, status) and last bit index
// ****************************************************************
`define FWLSP_CNT_OPCODE   3'h1
`define FWLSP_CNT_ADDR     3'h4
`define FWLSP_CNT_DATA     3'h5
`define FWLSP_CNT_STATUS   3'h2
`define FWLSP_BIT_LAST     3'h7

// ****************************************************************
// Sector layout and reset values
// ****************************************************************
`define FWLSP_SECTOR_LSB   17
`define FWLSP_FLAG_PROT    1'b1
`define FWLSP_FLAG_OPEN    1'b0
`define FWLSP_WEN_RST      1'b0

`endif

// ---- pkg/fwlsp_pkg.sv ----
// Types shared by the flash command and sector protection block.
// Assumes nothing of its surroundings.
package fwlsp_pkg;

    // Command parser states, one-hot
    typedef enum logic [3:0] {
        FWLSP_S_IDLE = 4'h1,
        FWLSP_S_ADDR = 4'h2,
        FWLSP_S_DATA = 4'h4,
        FWLSP_S_TAIL = 4'h8
    } fwlsp_state_t;

endpackage

// ---- rtl/fwlsp_rx.sv ----
// Serial byte receiver: synchronises the link pins and assembles bytes.
// Assumes the pins come from outside the clock domain and that the
// serial clock is well below a quarter of the system clock.
`timescale 1ns/10ps
`default_nettype none
`include "fwlsp_regs.svh"

module fwlsp_rx (
    input  wire logic       clock,       // System clock
    input  wire logic       rstn,        // Async reset, active low
    input  wire logic       cs_n,        // Chip select pin, active low
    input  wire logic       sck,         // Serial clock pin
    input  wire logic       si,          // Serial data pin
    output logic            byte_valid,  // Pulse: a whole byte arrived
    output logic [7:0]      byte_data,   // Byte, MSB first on the wire
    output logic            frame_end    // Pulse: chip select released
);

    logic       cs_s1_q, cs_s2_q, cs_s3_q;
    logic       sck_s1_q, sck_s2_q, sck_s3_q;
    logic       si_s1_q, si_s2_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic       rise;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // First stages feed only the second stages
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            cs_s3_q  <= 1'b1;
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            si_s1_q  <= 1'b0;
            si_s2_q  <= 1'b0;
        end else begin
            cs_s1_q  <= cs_n;
            cs_s2_q  <= cs_s1_q;
            cs_s3_q  <= cs_s2_q;
            sck_s1_q <= sck;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            si_s1_q  <= si;
            si_s2_q  <= si_s1_q;
        end
    end

    // Data is sampled on rising serial clock edges inside a frame
    assign rise = sck_s2_q & ~sck_s3_q & ~cs_s2_q;  // RULE15

    // ****************************************************************
    // Shifter
    // ****************************************************************
    // A partial byte is dropped when the frame ends
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bit_q      <= 3'h0;
            shift_q    <= 8'h00;
            byte_valid <= 1'b0;
            byte_data  <= 8'h00;
        end else begin
            byte_valid <= 1'b0;
            if (cs_s2_q) begin
                bit_q <= 3'h0;
            end else if (rise) begin
                shift_q <= {shift_q[6:0], si_s2_q};  // RULE15
                bit_q   <= bit_q + 3'h1;
                if (bit_q == `FWLSP_BIT_LAST) begin
                    byte_valid <= 1'b1;
                    byte_data  <= {shift_q[6:0], si_s2_q};
                end
            end
        end
    end

    // Release of chip select closes the frame
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            frame_end <= 1'b0;
        end else begin
            frame_end <= cs_s2_q & ~cs_s3_q;  // RULE15
        end
    end

endmodule
`default_nettype wire

// ---- test/fwlsp_host_model.sv ----
// Behavioural SPI host that frames commands for the protection block.
// Assumes the caller hands it left-aligned bits and the system clock.
`timescale 1ns/10ps
`default_nettype none

module fwlsp_host_model (
    input  wire logic clock,   // System clock, paces the serial phases
    output logic      cs_n,    // Chip select, active low
    output logic      sck,     // Serial clock, still outside frames
    output logic      si       // Serial data, MSB first
);
    // ****************************************************************
    // Framing
    // ****************************************************************
    // Four system clocks a phase keep clear of the three-flop sampler
    localparam int HALF = 4;

    // Idle pins at time zero
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    // One frame: cs_n low, nbits MSB first on rising sck, then release
    task automatic frame(input logic [39:0] d, input int nbits);
        @(posedge clock);
        cs_n <= 1'b0;
        repeat (HALF) @(posedge clock);
        for (int i = 0; i < nbits; i++) begin
            si <= d[39-i];
            repeat (HALF) @(posedge clock);
            sck <= 1'b1;
            repeat (HALF) @(posedge clock);
            sck <= 1'b0;
        end
        repeat (HALF) @(posedge clock);
        cs_n <= 1'b1;
        // Released data line shows the inverse so no stale bit passes
        si   <= ~si;
        repeat (6) @(posedge clock);
    endtask
endmodule

`default_nettype wire

// ---- test/fwlsp_tb_top.sv ----
// Self-checking bench of the write-enable latch and sector flags.
// Assumes the host model drives the link; lock is driven here.
`timescale 1ns/10ps
`default_nettype none
`include "fwlsp_regs.svh"
`define CHK(g, e) chk(40'(g), 40'(e))

module fwlsp_tb_top;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clock = 1'b0;  // 10 MHz
    logic        rstn  = 1'b0;  // Reset, active low
    logic        lock  = 1'b0;  // Flags locked
    logic        cs_n;          // Link pins from the host model
    logic        sck;
    logic        si;
    logic        wen;           // Latch state
    logic [15:0] flags;         // Sector flags
    logic        seq_exit;      // Pulses from the design
    logic        start;
    logic        stat_wr;
    logic [7:0]  op_q;          // Started opcode and address
    logic [23:0] addr_q;
    logic [7:0]  n_start = 8'h00; // Pulse tallies
    logic [7:0]  n_seq   = 8'h00;
    logic [7:0]  n_stat  = 8'h00;
    logic [15:0] exp_f;         // Expected flags
    int          error_cnt = 0;
    int          n_checks  = 0;

    // Free-running clock
    initial begin
        forever #50 clock = ~clock;
    end

    fwlsp_host_model i_host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si));

    fwlsp_top #(.NSEC(16)) i_dut (
        .clock(clock), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si),
        .protection_flags_lock(lock), .write_enable_latch(wen),
        .sector_flags(flags), .seq_mode_exit(seq_exit), .exec_start(start),
        .exec_opcode(op_q), .exec_addr(addr_q), .status_write(stat_wr)
    );

    // Pulses last one cycle, so they are tallied at every edge
    always @(posedge clock) begin
        if (start === 1'b1) n_start <= n_start + 8'h01;
        if (seq_exit === 1'b1) n_seq <= n_seq + 8'h01;
        if (stat_wr === 1'b1) n_stat <= n_stat + 8'h01;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic close_out();
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Frame then let the decision land (eight clocks after cs_n rise)
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nbits);
        i_host.frame({op, a, 8'hA5}, nbits);
        repeat (2) @(posedge clock);
    endtask

    task automatic wren();
        cmd(`FWLSP_OP_WREN, 24'h000000, 8);
    endtask

    function automatic logic [23:0] sa(input int s);
        return 24'(s) << `FWLSP_SECTOR_LSB;
    endfunction

    // Watchdog, well beyond the twelve thousand clocks the run needs
    initial begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        close_out();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        exp_f = 16'hFFFF;
        `CHK(flags, exp_f);
        `CHK(wen, `FWLSP_WEN_RST);
        // Guarded commands with the latch clear do nothing
        cmd(`FWLSP_OP_PROGRAM, sa(3), 40);
        cmd(`FWLSP_OP_WSR, 24'h000000, 16);
        `CHK({n_start, n_stat}, 16'h0000);
        // Short and complete enable and disable opcodes
        cmd(`FWLSP_OP_WREN, 24'h000000, 7);
        `CHK(wen, 1'b0);
        cmd(`FWLSP_OP_WREN, 24'h000000, 16);
        `CHK(wen, 1'b1);
        cmd(`FWLSP_OP_WRDI, 24'h000000, 7);
        `CHK(wen, 1'b1);
        cmd(`FWLSP_OP_WRDI, 24'h000000, 16);
        `CHK(wen, 1'b0);
        `CHK(n_seq, 8'h01);
        // Sector 1 comes out only if address bytes go MSB first
        wren();
        cmd(`FWLSP_OP_UNPROT, sa(1), 40);
        exp_f[1] = 1'b0;
        `CHK(flags, exp_f);
        `CHK(wen, 1'b0);
        wren();
        cmd(`FWLSP_OP_UNPROT, sa(3) | 24'h01FFFF, 32);
        exp_f[3] = 1'b0;
        `CHK(flags, exp_f);
        // Erase into an open sector starts and clears the latch
        wren();
        cmd(`FWLSP_OP_ERASE_4K, sa(3) | 24'h000ABC, 32);
        `CHK({n_start, op_q, addr_q}, {8'h01, `FWLSP_OP_ERASE_4K, sa(3) | 24'h000ABC});
        `CHK(wen, 1'b0);
        wren();
        cmd(`FWLSP_OP_PROGRAM, sa(1), 40);
        `CHK({n_start, op_q}, {8'h02, `FWLSP_OP_PROGRAM});
        // Program and erases into protected sector 5 are dropped
        for (int k = 0; k < 4; k++) begin
            wren();
            case (k)
                0: cmd(`FWLSP_OP_PROGRAM, sa(5), 40);
                1: cmd(`FWLSP_OP_ERASE_4K, sa(5), 32);
                2: cmd(`FWLSP_OP_ERASE_32K, sa(5), 32);
                default: cmd(`FWLSP_OP_ERASE_64K, sa(5), 32);
            endcase
            `CHK({n_start, wen}, {8'h02, 1'b0});
        end
        // Chip erase with flags set is dropped, both opcodes
        wren();
        cmd(`FWLSP_OP_CHIP_A, 24'h000000, 8);
        wren();
        cmd(`FWLSP_OP_CHIP_B, 24'h000000, 16);
        `CHK({n_start, wen}, {8'h02, 1'b0});
        // Protect sector 1 again
        wren();
        cmd(`FWLSP_OP_PROT, sa(1), 40);
        exp_f[1] = 1'b1;
        `CHK({flags, wen}, {exp_f, 1'b0});
        // Address cut short: flags kept, latch cleared
        wren();
        cmd(`FWLSP_OP_PROT, sa(3), 24);
        `CHK({flags, wen}, {exp_f, 1'b0});
        // Locked flags ignore unprotect
        lock <= 1'b1;
        wren();
        cmd(`FWLSP_OP_UNPROT, sa(5), 32);
        `CHK({flags, wen}, {exp_f, 1'b0});
        lock <= 1'b0;
        // Status write allowed once the latch is set
        wren();
        cmd(`FWLSP_OP_WSR, 24'h000000, 16);
        `CHK(n_stat, 8'h01);
        // With every sector open the chip erase runs
        for (int s = 0; s < 16; s++) begin
            wren();
            cmd(`FWLSP_OP_UNPROT, sa(s), 32);
        end
        `CHK(flags, 16'h0000);
        wren();
        cmd(`FWLSP_OP_CHIP_A, 24'h000000, 8);
        `CHK({n_start, op_q}, {8'h03, `FWLSP_OP_CHIP_A});
        close_out();
    end
endmodule

`default_nettype wire
